// [core/ntac_consts.vh]
// constants for the nonvolatile table access control block
`ifndef NTAC_CONSTS_VH
`define NTAC_CONSTS_VH
// register byte offsets
`define NTAC_OFS_CTRL     8'h00
`define NTAC_OFS_UNLOCK   8'h04
`define NTAC_OFS_PTR      8'h08
`define NTAC_OFS_LATCH    8'h0C
`define NTAC_OFS_TBLOP    8'h10
`define NTAC_OFS_STATUS   8'h14
// control register field positions
`define NTAC_CTL_REG_LO   0
`define NTAC_CTL_REG_HI   1
`define NTAC_CTL_ERASE    2
`define NTAC_CTL_WRITE_ENABLE_BIT     3
`define NTAC_CTL_WR       4
`define NTAC_CTL_ERR      5
`define NTAC_CTL_DONE     6
// table operation register bits
`define NTAC_OP_READ      0
`define NTAC_OP_WRITE     1
`define NTAC_OP_BULK      2
// region select codes
`define NTAC_REG_EEPROM   2'h0
`define NTAC_REG_PFM      2'h2
// unlock keys
`define NTAC_KEY1         8'h55
`define NTAC_KEY2         8'hAA
// address windows of the table pointer
`define NTAC_UID_BASE     22'h200000
`define NTAC_UID_LAST     22'h20000F
`define NTAC_CFG_BASE     22'h300000
`define NTAC_CFG_LAST     22'h30000B
`define NTAC_ID_BASE      22'h3FFFFC
// sizes: 16384 words of flash, 64 byte latch block = one 32 word row
`define NTAC_PFM_BYTES    32768
`define NTAC_ROW_BYTES    64
`define NTAC_UID_BYTES    16
`define NTAC_CFG_BYTES    12
// configuration bytes holding protection bits (active low)
`define NTAC_CFG_WRT_IDX  7
`define NTAC_CFG_CP_IDX   8
`define NTAC_CFG_CP_BIT   0
// reset values
`define NTAC_ERASED       8'hFF
`define NTAC_RST_CTRL     7'h00
// programming time in microseconds and clock rate in MHz
`define NTAC_PROG_TIME_US 2
`define NTAC_CLK_MHZ      25
`define NTAC_PROG_CYCLES  (`NTAC_PROG_TIME_US * `NTAC_CLK_MHZ)
`endif

// [core/ntac_top.v]
// nonvolatile table access control block with apb register port
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "ntac_consts.vh"

module ntac_top #(
  parameter [15:0] PROG_CYCLES = `NTAC_PROG_CYCLES   // programming timer length in clocks
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // external programmer mode pin
  input  wire        progModePin,
  // core stall
  output reg         cpuStall
);

  ////////////////////////////////////////////////////////////////////////////
  // state codes
  localparam [2:0] ST_IDLE = 3'b001;   // waiting for a start
  localparam [2:0] ST_PROG = 3'b010;   // timer running
  localparam [2:0] ST_BULK = 3'b100;   // walking the whole flash

  ////////////////////////////////////////////////////////////////////////////
  // storage
  reg  [7:0]  pfmMem   [0:`NTAC_PFM_BYTES-1];   // program flash array
  reg  [7:0]  uidMem_r [0:`NTAC_UID_BYTES-1];   // user id bytes
  reg  [7:0]  cfgMem_r [0:`NTAC_CFG_BYTES-1];   // configuration bytes
  reg  [7:0]  latchMem_r [0:`NTAC_ROW_BYTES-1]; // write holding latches

  // control and data registers
  reg  [1:0]  regionSel_r;     // mem_region_select
  reg         eraseSel_r;      // row erase on next start
  reg         writeEnable_r;   // write_enable_bit
  reg         writeStart_r;    // start bit, set only
  reg         writeError_r;    // write_error_flag
  reg         nvmDone_r;       // nvm_done_flag
  reg  [21:0] tablePtr_r;      // table_pointer
  reg  [7:0]  tableLatch_r;    // table_latch
  reg  [1:0]  unlockStep_r;    // unlock progress
  reg  [2:0]  state_r;         // operation state
  reg  [15:0] timer_r;         // programming timer
  reg  [14:0] bulkIdx_r;       // bulk erase walk index
  reg         progSync1_r;     // programmer pin sync stage one
  reg         progSync2_r;     // programmer pin sync stage two

  integer     i;               // loop index of the flash block
  integer     k;               // loop index of the id and config block

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        apbAccess = psel & penable & pready;   // completing edge
  wire        apbWr     = apbAccess & pwrite;        // write takes effect
  wire        apbRd     = psel & penable & ~pready;  // read data captured
  wire        wrCtrl    = apbWr & (paddr == `NTAC_OFS_CTRL);
  wire        wrUnlock  = apbWr & (paddr == `NTAC_OFS_UNLOCK);
  wire        wrPtr     = apbWr & (paddr == `NTAC_OFS_PTR);
  wire        wrLatch   = apbWr & (paddr == `NTAC_OFS_LATCH);
  wire        wrOp      = apbWr & (paddr == `NTAC_OFS_TBLOP);
  wire        mapped    = (paddr == `NTAC_OFS_CTRL) | (paddr == `NTAC_OFS_UNLOCK) |
                          (paddr == `NTAC_OFS_PTR) | (paddr == `NTAC_OFS_LATCH) |
                          (paddr == `NTAC_OFS_TBLOP) | (paddr == `NTAC_OFS_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // address classification
  wire        inPfm   = (tablePtr_r[21:15] == 7'h00);                 // inside flash
  wire        inUid   = (tablePtr_r >= `NTAC_UID_BASE) & (tablePtr_r <= `NTAC_UID_LAST);
  wire        inCfg   = (tablePtr_r >= `NTAC_CFG_BASE) & (tablePtr_r <= `NTAC_CFG_LAST);
  wire        inId    = (tablePtr_r >= `NTAC_ID_BASE);
  wire        selPfm  = (regionSel_r == `NTAC_REG_PFM);
  wire        selCfg  = regionSel_r[0];
  wire        progMode   = progSync2_r;                               // programmer attached
  wire [7:0]  cpByte     = cfgMem_r[`NTAC_CFG_CP_IDX];
  wire [7:0]  wrtByte    = cfgMem_r[`NTAC_CFG_WRT_IDX];
  wire        codeProt   = ~cpByte[`NTAC_CFG_CP_BIT];                 // active low bit
  wire        pfmLocked  = progMode & codeProt;
  wire        wrtHit     = ~progMode & ~wrtByte[tablePtr_r[14:13]];
  wire [14:0] pfmAddr    = tablePtr_r[14:0];
  wire [14:0] rowBase    = {tablePtr_r[14:6], 6'h00};

  // identity bytes, arbitrary values
  wire [7:0]  idByte = {6'h00, tablePtr_r[1:0]};

  // array words picked by continuous assigns, so a cell that changes
  // under a steady pointer still reaches the read mux
  wire [7:0]  pfmByte = pfmMem[pfmAddr];                              // flash byte at pointer
  wire [7:0]  uidByte = uidMem_r[tablePtr_r[3:0]];                    // user id byte at pointer
  wire [7:0]  cfgByte = cfgMem_r[tablePtr_r[3:0]];                    // config byte at pointer

  // table read source, zero on reserved paths
  reg  [7:0]  readByte;
  always @* begin
    readByte = 8'h00;
    if (selPfm & inPfm & ~pfmLocked)
      readByte = pfmByte;
    else if (selCfg & inUid)
      readByte = uidByte;
    else if (selCfg & inCfg)
      readByte = cfgByte;
    else if (selCfg & inId)
      readByte = idByte;
  end

  // start request checks
  // a refused start leaves the start bit low and raises the error flag
  wire        unlocked  = (unlockStep_r == 2'h2);                     // keys seen
  wire        startReq  = wrCtrl & pwdata[`NTAC_CTL_WR] & ~writeStart_r & writeEnable_r & unlocked;
  wire        pfmOk     = selPfm & inPfm & ~wrtHit & ~pfmLocked;
  wire        cfgOk     = selCfg & (inUid | inCfg) & ~eraseSel_r;
  wire        startOk   = startReq & (state_r == ST_IDLE) & (pfmOk | cfgOk);
  wire        startBad  = startReq & ~(pfmOk | cfgOk);
  wire        bulkReq   = wrOp & pwdata[`NTAC_OP_BULK];
  wire        bulkOk    = bulkReq & progMode & (state_r == ST_IDLE);
  wire        bulkBad   = bulkReq & ~progMode;
  wire        tblWrite  = wrOp & pwdata[`NTAC_OP_WRITE] & (state_r == ST_IDLE);
  wire        tblRead   = wrOp & pwdata[`NTAC_OP_READ] & (state_r == ST_IDLE);
  wire        timerDone = (state_r == ST_PROG) & (timer_r == PROG_CYCLES - 16'h0001);
  wire        doErase   = startOk & selPfm & eraseSel_r;
  wire        doWrite   = startOk & selPfm & ~eraseSel_r;

  ////////////////////////////////////////////////////////////////////////////
  // programmer pin synchroniser
  // the pin is asynchronous: only the second stage is read
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      progSync1_r <= 1'b0;
      progSync2_r <= 1'b0;
    end else begin
      progSync1_r <= progModePin;
      progSync2_r <= progSync1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, pready from a flop
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      // one pulse per access, in the second access cycle
      pready  <= apbRd;
      pslverr <= apbRd & ~mapped;
      if (apbRd & ~pwrite) begin
        case (paddr)
          `NTAC_OFS_CTRL:   prdata <= {25'h0, nvmDone_r, writeError_r, writeStart_r,
                                       writeEnable_r, eraseSel_r, regionSel_r};
          `NTAC_OFS_PTR:    prdata <= {10'h000, tablePtr_r};
          `NTAC_OFS_LATCH:  prdata <= {24'h00_0000, tableLatch_r};
          `NTAC_OFS_STATUS: prdata <= {29'h0, codeProt, progMode, cpuStall};
          default:          prdata <= 32'h0000_0000;   // unlock, op, unmapped
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register and unlock sequence
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {nvmDone_r, writeError_r, writeStart_r, writeEnable_r, eraseSel_r, regionSel_r} <= `NTAC_RST_CTRL;
      unlockStep_r <= 2'h0;
    end else begin
      if (wrCtrl) begin
        regionSel_r   <= pwdata[`NTAC_CTL_REG_HI:`NTAC_CTL_REG_LO];
        eraseSel_r    <= pwdata[`NTAC_CTL_ERASE];
        writeEnable_r <= pwdata[`NTAC_CTL_WRITE_ENABLE_BIT];
      end
      // a written zero in the start field is simply ignored
      // start bit: software only sets, hardware clears at expiry
      if (startOk | bulkOk)
        writeStart_r <= 1'b1;
      else if (timerDone)
        writeStart_r <= 1'b0;
      // error: set on refusal, cleared on clean completion
      if (startBad | bulkBad)
        writeError_r <= 1'b1;
      else if (timerDone)
        writeError_r <= 1'b0;
      // done flag: set wins over a software clear
      if (timerDone)
        nvmDone_r <= 1'b1;
      else if (wrCtrl & ~pwdata[`NTAC_CTL_DONE])
        nvmDone_r <= 1'b0;
      // reads leave the sequence intact
      // unlock: 55h then aah, any other write breaks it
      if (wrUnlock & (pwdata[7:0] == `NTAC_KEY1))
        unlockStep_r <= 2'h1;
      else if (wrUnlock & (pwdata[7:0] == `NTAC_KEY2) & (unlockStep_r == 2'h1))
        unlockStep_r <= 2'h2;
      else if (apbWr & ~(wrCtrl & unlocked & pwdata[`NTAC_CTL_WR]))
        unlockStep_r <= 2'h0;
      else if (wrCtrl)
        unlockStep_r <= 2'h0;                                         // used once
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointer and table latch
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tablePtr_r   <= 22'h00_0000;
      tableLatch_r <= 8'h00;
    end else begin
      if (wrPtr)
        tablePtr_r <= pwdata[21:0];
      // a table read beats a latch write on the same edge
      if (tblRead)
        tableLatch_r <= readByte;
      else if (wrLatch)
        tableLatch_r <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write holding latches, one per byte
  // op and control writes never share an edge, so fill never meets a row write flush; a fill beats a bulk flush
  genvar g;
  generate
    for (g = 0; g < `NTAC_ROW_BYTES; g = g + 1) begin : gLatch
      always @(posedge clk or posedge rst) begin
        if (rst)
          latchMem_r[g] <= `NTAC_ERASED;
        else if (tblWrite & (tablePtr_r[5:0] == g))
          latchMem_r[g] <= tableLatch_r;
        else if (doWrite | bulkOk)
          latchMem_r[g] <= `NTAC_ERASED;                              // blank after use
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and programming timer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r   <= ST_IDLE;
      timer_r   <= 16'h0000;
      bulkIdx_r <= 15'h0000;
      cpuStall  <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          timer_r   <= 16'h0000;
          bulkIdx_r <= 15'h0000;
          if (bulkOk) begin
            state_r  <= ST_BULK;
            cpuStall <= 1'b1;
          end else if (startOk) begin
            state_r  <= ST_PROG;
            cpuStall <= 1'b1;
          end
        end
        ST_BULK: begin
          // one flash byte per clock, then the normal timer
          bulkIdx_r <= bulkIdx_r + 15'h0001;
          if (bulkIdx_r == `NTAC_PFM_BYTES - 1)
            state_r <= ST_PROG;
        end
        ST_PROG: begin
          timer_r <= timer_r + 16'h0001;
          if (timerDone) begin
            state_r  <= ST_IDLE;
            cpuStall <= 1'b0;
          end
        end
        default: begin
          state_r  <= ST_IDLE;
          cpuStall <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash array updates, no reset on nonvolatile cells
  always @(posedge clk) begin
    // erase and write exclude each other through the erase select bit
    if (doErase) begin
      for (i = 0; i < `NTAC_ROW_BYTES; i = i + 1)
        pfmMem[rowBase | i[14:0]] <= `NTAC_ERASED;
    end else if (doWrite) begin
      // programming only clears bits, blank latches keep old data
      for (i = 0; i < `NTAC_ROW_BYTES; i = i + 1)
        pfmMem[rowBase | i[14:0]] <= pfmMem[rowBase | i[14:0]] & latchMem_r[i];
    end else if (state_r == ST_BULK) begin
      pfmMem[bulkIdx_r] <= `NTAC_ERASED;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user id and configuration bytes, erased state at reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (k = 0; k < `NTAC_UID_BYTES; k = k + 1)
        uidMem_r[k] <= `NTAC_ERASED;
      for (k = 0; k < `NTAC_CFG_BYTES; k = k + 1)
        cfgMem_r[k] <= `NTAC_ERASED;
    end else if (bulkOk) begin
      for (k = 0; k < `NTAC_UID_BYTES; k = k + 1)
        uidMem_r[k] <= `NTAC_ERASED;
      for (k = 0; k < `NTAC_CFG_BYTES; k = k + 1)
        cfgMem_r[k] <= `NTAC_ERASED;
    end else if (startOk & selCfg & inUid) begin
      uidMem_r[tablePtr_r[3:0]] <= tableLatch_r;
    end else if (startOk & selCfg & inCfg) begin
      // programming only clears bits, so protection sticks until bulk erase or reset
      cfgMem_r[tablePtr_r[3:0]] <= cfgByte & tableLatch_r;
    end
  end

endmodule

// [testbench/ntac_asserts.sv]
// checker for the register port and stall timing
`timescale 1ns/1ps
module ntac_asserts #(
  parameter [15:0] PROG_CYCLES = 16'h0032
) (
  // clock and reset
  input wire        clk,
  input wire        rst,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // pins
  input wire        progModePin,
  input wire        cpuStall
);
  reg  [31:0] stallLen_r;                                // length of the running stall
  wire        accEnd = psel && penable && pready;        // completing edge
  wire        mapped = (paddr <= 8'h14) && (paddr[1:0] == 2'h0);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // count cycles while the core is held
  always @(posedge clk or posedge rst) begin
    if (rst) stallLen_r <= 32'h0;
    else if (cpuStall) stallLen_r <= stallLen_r + 32'h1;
    else stallLen_r <= 32'h0;
  end
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_ready_resp; psel && penable && !pready |=> pready; endproperty
  a_ready_resp: assert property (p_ready_resp) else $error("ready late");
  property p_ready_cause; pready |-> $past(psel && penable); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without access");
  property p_err_unmapped; accEnd && !mapped |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
  property p_ok_mapped; accEnd && mapped |-> !pslverr; endproperty
  a_ok_mapped: assert property (p_ok_mapped) else $error("mapped access refused");
  property p_latch_narrow; accEnd && !pwrite && paddr == 8'h0C |-> prdata[31:8] == 24'h0; endproperty
  a_latch_narrow: assert property (p_latch_narrow) else $error("latch wider than a byte");
  property p_stall_len; !progModePin && $fell(cpuStall) && !$past(rst) |-> stallLen_r == PROG_CYCLES; endproperty
  a_stall_len: assert property (p_stall_len) else $error("stall length wrong");
  property p_stall_cause; $rose(cpuStall) |-> $past(accEnd && pwrite); endproperty
  a_stall_cause: assert property (p_stall_cause) else $error("stall without a start write");
  c_stall: cover property ($fell(cpuStall));
  c_err: cover property (pslverr);
  c_bulk: cover property ($fell(cpuStall) && progModePin);
endmodule
bind ntac_top ntac_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .progModePin(progModePin), .cpuStall(cpuStall));

// [testbench/ntac_core_model.sv]
// core model issuing register accesses and table operations
`timescale 1ns/1ps
`include "ntac_consts.vh"
module ntac_core_model (
  // clock
  input  wire        clk,
  // apb master
  output reg         psel = 1'b0,
  output reg         penable = 1'b0,
  output reg         pwrite = 1'b0,
  output reg  [7:0]  paddr = 8'h00,
  output reg  [31:0] pwdata = 32'h0,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr,
  // programmer attach pin
  output reg         progModePin = 1'b0
);
  reg [31:0] rdData; // last word read
  reg        rdErr;  // last error answer
  // one transfer, held until ready is seen
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (!pready) @(posedge clk);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // idle data never repeats
    end
  endtask
  // key pair then start, with nothing between
  task unlockStart(input [31:0] ctl);
    begin
      xfer(1'b1, `NTAC_OFS_UNLOCK, {24'h0, `NTAC_KEY1});
      xfer(1'b1, `NTAC_OFS_UNLOCK, {24'h0, `NTAC_KEY2});
      xfer(1'b1, `NTAC_OFS_CTRL, ctl);
    end
  endtask
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the table access block
`timescale 1ns/1ps
`include "ntac_consts.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_top;
  localparam [15:0] PC = 16'h0004; // short programming time
  localparam [7:0]  CT = `NTAC_OFS_CTRL, PT = `NTAC_OFS_PTR, LA = `NTAC_OFS_LATCH, OP = `NTAC_OFS_TBLOP;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  wire        psel, penable, pwrite, pready, pslverr, progModePin, cpuStall;
  wire [7:0]  paddr;
  wire [31:0] pwdata, prdata;
  integer     mismatches = 0, compares = 0, seed = 32'h41bd, n;
  reg  [6:0]  i;
  reg  [7:0]  rowA [0:63]; // random row image
  reg  [7:0]  v;
  reg  [21:0] p;           // row base in quarter one
  ntac_top #(.PROG_CYCLES(PC)) dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .progModePin(progModePin), .cpuStall(cpuStall));
  ntac_core_model cm (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .progModePin(progModePin));
  initial begin
    forever #20 clk = ~clk;
  end
  function [7:0] progByte(input [7:0] o, input [7:0] l); progByte = o & l; endfunction
  task wr(input [7:0] a, input [31:0] d); cm.xfer(1'b1, a, d); endtask
  task rd(input [7:0] a); cm.xfer(1'b0, a, 32'h0); endtask
  // table read into the latch, then fetch it
  task tread(input [21:0] q);
    begin
      wr(PT, {10'h0, q});
      wr(OP, 32'h1);
      rd(LA);
    end
  endtask
  // one holding byte through the latch
  task tload(input [21:0] q, input [7:0] d);
    begin
      wr(PT, {10'h0, q});
      wr(LA, {24'h0, d});
      wr(OP, 32'h2);
    end
  endtask
  // wait out a running stall, bounded
  task waitStall;
    begin
      n = 0;
      repeat (2) @(posedge clk);
      while (cpuStall !== 1'b0 && n < 40000) begin
        @(posedge clk);
        n = n + 1;
      end
      rd(CT);
    end
  endtask
  // enable, unlock, start and wait
  task go(input [1:0] rg, input er);
    begin
      wr(CT, {28'h0, 1'b1, er, rg});
      cm.unlockStart({27'h0, 2'b11, er, rg});
      waitStall;
    end
  endtask
  task give_verdict;
    begin
      $display("counts: %0d compares, %0d mismatches", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // watchdog
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    give_verdict;
  end
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(CT); `CHK("ctrl reset", 32'h0, cm.rdData)
    rd(8'h18); `CHK("unmapped", 1'b1, cm.rdErr)
    v = $random(seed);
    p = 22'h002000 + {9'h0, v[6:0], 6'h00};
    wr(PT, {10'h0, p});
    go(2'b10, 1'b1); `CHK("erase ctrl", 3'b100, cm.rdData[6:4])
    for (i = 0; i < 64; i = i + 7'h1) begin tread(p + i); `CHK("erased", 8'hFF, cm.rdData[7:0]) end
    for (i = 0; i < 64; i = i + 7'h1) begin rowA[i] = $random(seed); tload(p + i, rowA[i]); end
    go(2'b10, 1'b0); `CHK("write ctrl", 3'b100, cm.rdData[6:4])
    for (i = 0; i < 64; i = i + 7'h1) begin tread(p + i); `CHK("row", rowA[i], cm.rdData[7:0]) end
    v = $random(seed);
    for (i = 0; i < 64; i = i + 7'h1) tload(p + i, (i == 9) ? v : 8'hFF);
    go(2'b10, 1'b0);
    for (i = 0; i < 64; i = i + 7'h1) begin
      tread(p + i);
      `CHK("reprogram", progByte(rowA[i], (i == 9) ? v : 8'hFF), cm.rdData[7:0])
    end
    $display("test flash row done");
    wr(CT, 32'h4A); rd(CT); `CHK("done kept", 1'b1, cm.rdData[6])
    wr(CT, 32'h0A); rd(CT); `CHK("done clear", 1'b0, cm.rdData[6])
    go(2'b00, 1'b0); `CHK("eeprom start", 2'b10, cm.rdData[5:4])
    go(2'b11, 1'b1); `CHK("id erase", 2'b10, cm.rdData[5:4])
    wr(PT, 32'h200010);
    go(2'b01, 1'b0); `CHK("reserved start", 2'b10, cm.rdData[5:4])
    tread(22'h200010); `CHK("reserved read", 8'h00, cm.rdData[7:0])
    v = $random(seed);
    tload(22'h200003, v);
    go(2'b01, 1'b0); `CHK("id write", 3'b100, cm.rdData[6:4])
    tread(22'h200003); `CHK("id byte", v, cm.rdData[7:0])
    wr(OP, 32'h4); rd(CT); `CHK("user bulk", 1'b1, cm.rdData[5])
    `CHK("no bulk stall", 1'b0, cpuStall)
    $display("test regions done");
    tload(22'h300007, 8'hF0);
    go(2'b01, 1'b0);
    wr(PT, {10'h0, p});
    go(2'b10, 1'b1); `CHK("protected erase", 2'b10, cm.rdData[5:4])
    tread(p); `CHK("kept row", rowA[0], cm.rdData[7:0])
    tload(22'h300008, 8'hFE);
    go(2'b01, 1'b0);
    tload(22'h300008, 8'hFF);
    go(2'b01, 1'b0);
    tread(22'h300008); `CHK("protect sticks", 8'hFE, cm.rdData[7:0])
    wr(CT, 32'h2);
    tread(p); `CHK("self read", rowA[0], cm.rdData[7:0])
    cm.progModePin <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`NTAC_OFS_STATUS); `CHK("status", 3'b110, cm.rdData[2:0])
    tread(p); `CHK("locked read", 8'h00, cm.rdData[7:0])
    wr(OP, 32'h4);
    waitStall;
    tread(p); `CHK("bulk flash", 8'hFF, cm.rdData[7:0])
    wr(CT, 32'h1);
    tread(22'h300008); `CHK("bulk cfg", 8'hFF, cm.rdData[7:0])
    $display("test protection done");
    give_verdict;
  end
endmodule
